// ==== rtl/ecc_pkg.sv ====
// constants and field layout of the externally clocked capture counter
// What this block does
// RL1 - mode 1 may count both clock edges
// RL2 - mode 2 counts one chosen edge only
// RL3 - mode 2 clocking runs beside reset slave mode
// RL4 - slave mode code 100 selects reset mode
// RL5 - master code 010 pulses trigger out on update
// RL6 - update event when counter reaches reload limit
// RL7 - trigger source picks one internal trigger input
// RL8 - external trigger prescaled before resynchronisation
// RL9 - counter and capture are 32 bits wide
// RL10 - trigger shares channel 1 pin; capture on 2
// RL11 - rising channel 2 edge copies counter to capture
// RL12 - dma moves each capture word to memory
// RL13 - reset trigger clears counter and prescaler next cycle
// RL14 - capture sets flag and optional dma request
// RL15 - capture while flag set sets overcapture flag
// RL16 - mode 2 enable makes prescaled trigger the clock
// RL17 - prescale code 10 divides by four
package ecc_pkg;
  localparam int CNT_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 18;
  localparam int STAT_W = 4;
  localparam int PRESC_W = 2;
  localparam int MODE_W = 3;
  localparam int EDGE_W = 2;
  localparam int DIV_W = 3;
  localparam int TRIG_N = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] A_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] A_CAPT2 = 8'h0C;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] A_MASK = 8'h14;
  // control register fields
  localparam int B_EN = 0;
  localparam int B_EXT2 = 1;
  localparam int B_FALL = 2;
  localparam int B_PRESC = 4;
  localparam int B_MASTER = 6;
  localparam int B_SLAVE = 9;
  localparam int B_TRIG_SRC = 12;
  localparam int B_DMA_EN = 15;
  localparam int B_EDGE1 = 16;
  // status and mask bits
  localparam int S_UPD = 0;
  localparam int S_CAP = 1;
  localparam int S_OVR = 2;
  localparam int S_TRG = 3;
  // mode codes
  localparam logic [MODE_W-1:0] SLAVE_RESET = 3'h4;
  localparam logic [MODE_W-1:0] SLAVE_EXTCLK1 = 3'h7;
  localparam logic [MODE_W-1:0] MASTER_UPDATE = 3'h2;
  localparam logic [PRESC_W-1:0] PRESC_DIV4 = 2'h2;
  localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h1;
  localparam logic [EDGE_W-1:0] EDGE_BOTH = 2'h2;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 18'h0_0000;
  localparam logic [CNT_W-1:0] LIMIT_RST = 32'hFFFF_FFFF;
  localparam logic [STAT_W-1:0] MASK_RST = 4'h0;
endpackage : ecc_pkg

// ==== rtl/ecc_trig_if.sv ====
// link between the timer core and the external trigger prescaler
`timescale 1ns/10ps
interface ecc_trig_if import ecc_pkg::*; ();
  logic [PRESC_W-1:0] ext_trigger_prescale;
  logic falling;
  logic clear;
  logic tick;
  modport timer (output ext_trigger_prescale, output falling, output clear, input tick);
  modport presc (input ext_trigger_prescale, input falling, input clear, output tick);
endinterface : ecc_trig_if

// ==== rtl/ecc_trig_prescaler.sv ====
// external trigger edge prescaler with resynchronising stage
`timescale 1ns/10ps
module ecc_trig_prescaler import ecc_pkg::*; (
  // clock, enable and reset
  input logic clk,
  input logic rst_n,
  input logic ce,
  // shared pin level
  input logic trig_pin,
  // timer side
  ecc_trig_if.presc pif
);
  logic pin_q, pin_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [DIV_W-1:0] last;
  logic prescaled_ext_trigger_q, prescaled_ext_trigger_d;
  logic [2:0] sync_q, sync_d;
  logic tick_q, tick_d;
  logic active;

  always_comb begin
    pin_d = trig_pin;
    last = DIV_W'((1 << pif.ext_trigger_prescale) - 1); // RL17
    active = pif.falling ? (pin_q & ~trig_pin) : (~pin_q & trig_pin);
    div_d = div_q;
    prescaled_ext_trigger_d = prescaled_ext_trigger_q;
    if (pif.clear) begin
      div_d = '0; // RL13
    end else if (active) begin
      if (div_q == last) begin
        div_d = '0;
        prescaled_ext_trigger_d = ~prescaled_ext_trigger_q; // RL8
      end else begin
        div_d = div_q + 1'b1;
      end
    end
    sync_d = {sync_q[1:0], prescaled_ext_trigger_q}; // RL8
    tick_d = sync_q[1] ^ sync_q[2];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      div_q <= '0;
      prescaled_ext_trigger_q <= 1'b0;
      sync_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      pin_q <= pin_d;
      div_q <= div_d;
      prescaled_ext_trigger_q <= prescaled_ext_trigger_d;
      sync_q <= sync_d;
      tick_q <= tick_d;
    end
  end

  assign pif.tick = tick_q;

  a_prescale_ratio: assert property (@(posedge clk) disable iff (!rst_n) // RL17
    (ce && active && !pif.clear && div_q != last) |=> (prescaled_ext_trigger_q == $past(prescaled_ext_trigger_q)))
    else $error("prescaler toggled before its ratio");
endmodule : ecc_trig_prescaler

// ==== rtl/ecc_timer.sv ====
// externally clocked 32-bit timer with reset slave mode and channel 2 capture
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
module ecc_timer import ecc_pkg::*; (
  // clock, enable and reset
  input logic CLK,
  input logic CE,
  input logic RST_B,
  // register port
  input logic [ADDR_W-1:0] ADDR,
  input logic [DATA_W-1:0] WDATA,
  input logic WR,
  input logic RD,
  output logic [DATA_W-1:0] RDATA,
  // shared channel 1 / external trigger pin and channel 2 pin
  input logic CH1_EXT_TRIG,
  input logic CH2_IN,
  // trigger link between timers
  input logic [TRIG_N-1:0] INT_TRIG,
  output logic TRIG_OUT,
  // dma handshake
  output logic DMA_REQ,
  input logic DMA_ACK,
  // interrupt
  output logic IRQ
);
  // reset release
  logic [1:0] rst_sync_q, rst_sync_d;
  logic rst_n;

  always_comb begin
    rst_sync_d = {rst_sync_q[0], 1'b1};
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= rst_sync_d;
    end
  end

  assign rst_n = rst_sync_q[1];

  // configuration registers
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [CNT_W-1:0] auto_reload_limit_q, auto_reload_limit_d;
  logic [STAT_W-1:0] mask_q, mask_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  // counting state
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] capture_value_ch2_q, capture_value_ch2_d;
  logic [STAT_W-1:0] stat_q, stat_d;
  logic [STAT_W-1:0] stat_set, stat_clr;
  logic trig_q, trig_d;
  logic pin1_q, pin1_d;
  logic ch2_q, ch2_d;
  logic trigger_out_pulse_q, trigger_out_pulse_d;
  logic dma_q, dma_d;
  // decoded fields and events
  logic counter_enable;
  logic ext_clock_mode2_enable;
  logic [MODE_W-1:0] master_mode_select;
  logic [MODE_W-1:0] slave_mode_select;
  logic [MODE_W-1:0] trigger_source_select;
  logic [EDGE_W-1:0] mode1_edge_select;
  logic capture_dma_enable;
  logic trig_in;
  logic slave_reset;
  logic pin_rise, pin_fall, mode1_edge;
  logic count_tick;
  logic update;
  logic cnt_wr;
  logic cap_edge;
  logic irq_src;

  ecc_trig_if trig_link ();

  assign counter_enable = ctrl_q[B_EN];
  assign ext_clock_mode2_enable = ctrl_q[B_EXT2];
  assign master_mode_select = ctrl_q[B_MASTER +: MODE_W];
  assign slave_mode_select = ctrl_q[B_SLAVE +: MODE_W];
  assign trigger_source_select = ctrl_q[B_TRIG_SRC +: MODE_W];
  assign mode1_edge_select = ctrl_q[B_EDGE1 +: EDGE_W];
  assign capture_dma_enable = ctrl_q[B_DMA_EN];

  // external trigger path, fed from the channel 1 pin
  assign trig_link.ext_trigger_prescale = ctrl_q[B_PRESC +: PRESC_W]; // RL17
  assign trig_link.falling = ctrl_q[B_FALL]; // RL2
  assign trig_link.clear = slave_reset; // RL13

  ecc_trig_prescaler u_prescaler (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .trig_pin(CH1_EXT_TRIG), // RL10
    .pif(trig_link.presc)
  );

  // register port and interrupt
  always_comb begin
    ctrl_d = ctrl_q;
    auto_reload_limit_d = auto_reload_limit_q;
    mask_d = mask_q;
    rdata_d = '0;
    if (WR) begin
      case (ADDR)
        A_CTRL: ctrl_d = WDATA[CTRL_W-1:0];
        A_LIMIT: auto_reload_limit_d = WDATA;
        A_MASK: mask_d = WDATA[STAT_W-1:0];
        default: ;
      endcase
    end
    if (RD) begin
      case (ADDR)
        A_CTRL: rdata_d = DATA_W'(ctrl_q);
        A_LIMIT: rdata_d = auto_reload_limit_q;
        A_COUNT: rdata_d = cnt_q;
        A_CAPT2: rdata_d = capture_value_ch2_q; // RL12
        A_STATUS: rdata_d = DATA_W'(stat_q);
        A_MASK: rdata_d = DATA_W'(mask_q);
        default: rdata_d = '0;
      endcase
    end
    irq_d = irq_src;
  end

  assign irq_src = |(stat_q & mask_q);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      auto_reload_limit_q <= LIMIT_RST;
      mask_q <= MASK_RST;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else if (CE) begin
      ctrl_q <= ctrl_d;
      auto_reload_limit_q <= auto_reload_limit_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  // counter, capture, flags and trigger out
  always_comb begin
    trig_in = INT_TRIG[trigger_source_select]; // RL7
    slave_reset = (slave_mode_select == SLAVE_RESET) && trig_in && !trig_q; // RL4
    pin_rise = CH1_EXT_TRIG & ~pin1_q;
    pin_fall = ~CH1_EXT_TRIG & pin1_q;
    if (mode1_edge_select == EDGE_BOTH) begin
      mode1_edge = pin_rise | pin_fall; // RL1
    end else if (mode1_edge_select == EDGE_FALL) begin
      mode1_edge = pin_fall;
    end else begin
      mode1_edge = pin_rise;
    end
    if (!counter_enable) begin
      count_tick = 1'b0;
    end else if (ext_clock_mode2_enable) begin
      count_tick = trig_link.tick; // RL16
    end else if (slave_mode_select == SLAVE_EXTCLK1) begin
      count_tick = mode1_edge; // RL1
    end else begin
      count_tick = 1'b1;
    end
    update = count_tick && (cnt_q == auto_reload_limit_q) && !slave_reset; // RL6
    cnt_wr = WR && (ADDR == A_COUNT);
    cap_edge = CH2_IN && !ch2_q; // RL11
    cnt_d = cnt_q;
    if (slave_reset) begin
      cnt_d = '0; // RL3
    end else if (cnt_wr) begin
      cnt_d = WDATA;
    end else if (update) begin
      cnt_d = '0; // RL6
    end else if (count_tick) begin
      cnt_d = cnt_q + 1'b1; // RL9
    end
    capture_value_ch2_d = cap_edge ? cnt_q : capture_value_ch2_q; // RL11
    stat_set = '0;
    stat_set[S_UPD] = update;
    stat_set[S_CAP] = cap_edge; // RL14
    stat_set[S_OVR] = cap_edge && stat_q[S_CAP]; // RL15
    stat_set[S_TRG] = slave_reset;
    stat_clr = (WR && (ADDR == A_STATUS)) ? WDATA[STAT_W-1:0] : '0;
    stat_clr[S_CAP] = stat_clr[S_CAP] | DMA_ACK | (RD && (ADDR == A_CAPT2));
    stat_d = (stat_q & ~stat_clr) | stat_set;
    trigger_out_pulse_d = update && (master_mode_select == MASTER_UPDATE); // RL5
    dma_d = (cap_edge && capture_dma_enable) || (dma_q && !DMA_ACK); // RL14
    trig_d = trig_in;
    pin1_d = CH1_EXT_TRIG;
    ch2_d = CH2_IN;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      capture_value_ch2_q <= '0;
      stat_q <= '0;
      trig_q <= 1'b0;
      pin1_q <= 1'b0;
      ch2_q <= 1'b0;
      trigger_out_pulse_q <= 1'b0;
      dma_q <= 1'b0;
    end else if (CE) begin
      cnt_q <= cnt_d;
      capture_value_ch2_q <= capture_value_ch2_d;
      stat_q <= stat_d;
      trig_q <= trig_d;
      pin1_q <= pin1_d;
      ch2_q <= ch2_d;
      trigger_out_pulse_q <= trigger_out_pulse_d;
      dma_q <= dma_d;
    end
  end

  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign TRIG_OUT = trigger_out_pulse_q;
  assign DMA_REQ = dma_q;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_trig_edge;
    CE && (slave_mode_select == SLAVE_RESET) && INT_TRIG[trigger_source_select] && !trig_q;
  endsequence

  sequence s_cap_edge;
    CE && CH2_IN && !ch2_q;
  endsequence

  a_mode1_both: assert property ( // RL1
    (CE && counter_enable && !ext_clock_mode2_enable && slave_mode_select == SLAVE_EXTCLK1
     && mode1_edge_select == EDGE_BOTH && CH1_EXT_TRIG != pin1_q && cnt_q != auto_reload_limit_q && !cnt_wr)
    |=> cnt_q == $past(cnt_q) + 1)
    else $error("mode 1 missed a clock edge");

  a_mode2_hold: assert property ( // RL2 RL16
    (CE && counter_enable && ext_clock_mode2_enable && !trig_link.tick && !slave_reset && !cnt_wr)
    |=> cnt_q == $past(cnt_q))
    else $error("mode 2 counted without a prescaled tick");

  a_mode2_reset: assert property ( // RL3
    (CE && ext_clock_mode2_enable && slave_reset) |=> (cnt_q == '0 && stat_q[S_TRG]))
    else $error("reset slave mode ignored in mode 2");

  a_reset_slave: assert property ( // RL4 RL7 RL13
    s_trig_edge |=> (cnt_q == '0 && u_prescaler.div_q == '0))
    else $error("selected trigger did not reset the counter");

  a_trigger_out_pulse_update: assert property ( // RL5
    (CE && update && master_mode_select == MASTER_UPDATE && !cnt_wr) |=> (TRIG_OUT && cnt_q == '0))
    else $error("update did not pulse trigger out");

  a_wrap_limit: assert property ( // RL6
    (CE && count_tick && cnt_q == auto_reload_limit_q && !slave_reset && !cnt_wr) |=> (cnt_q == '0 && stat_q[S_UPD]))
    else $error("counter did not wrap at the limit");

  a_capture_copy: assert property ( // RL9 RL11
    s_cap_edge |=> (capture_value_ch2_q == $past(cnt_q) && stat_q[S_CAP]))
    else $error("capture value or flag wrong");

  a_dma_raise: assert property ( // RL14
    (s_cap_edge ##0 capture_dma_enable) |=> DMA_REQ ##1 (DMA_REQ || $past(DMA_ACK)))
    else $error("dma request lost before acknowledge");

  a_over_capture: assert property ( // RL15
    (s_cap_edge ##0 stat_q[S_CAP]) |=> stat_q[S_OVR])
    else $error("overcapture flag not set");

  a_read_count: assert property (
    (CE && RD && ADDR == A_COUNT) |=> RDATA == $past(cnt_q))
    else $error("count read data wrong");

  a_irq_level: assert property (
    $past(CE) |-> IRQ == $past(irq_src))
    else $error("interrupt level wrong");

  a_ce_freeze: assert property (
    !CE |=> (cnt_q == $past(cnt_q) && stat_q == $past(stat_q) && ctrl_q == $past(ctrl_q) && RDATA == $past(RDATA)))
    else $error("state moved while clock enable was low");

  a_count_write: assert property (
    (CE && cnt_wr && !slave_reset) |=> cnt_q == $past(WDATA))
    else $error("count write lost");

  a_capture_hold: assert property ( // RL11
    (CE && !cap_edge) |=> capture_value_ch2_q == $past(capture_value_ch2_q))
    else $error("capture value changed without an edge");

  sequence s_dma_ack;
    CE && DMA_REQ && DMA_ACK;
  endsequence

  a_dma_drop: assert property ( // RL14
    (s_dma_ack ##0 !(cap_edge && capture_dma_enable)) |=> !DMA_REQ)
    else $error("dma request held after acknowledge");

  a_flag_ack_clear: assert property ( // RL14
    (CE && DMA_ACK && !cap_edge) |=> !stat_q[S_CAP])
    else $error("acknowledge left capture flag set");

  a_rdata_idle: assert property (
    (CE && !RD) |=> RDATA == '0)
    else $error("read data not zero outside a read");

  a_ovr_hold: assert property ( // RL15
    (CE && !cap_edge && !(WR && ADDR == A_STATUS && WDATA[S_OVR])) |=> stat_q[S_OVR] == $past(stat_q[S_OVR]))
    else $error("overcapture flag changed without cause");
endmodule : ecc_timer

// ==== dv/ecc_dma_model.sv ====
// dma controller model moving channel 2 captures into a word buffer
`timescale 1ns/10ps
module ecc_dma_model import ecc_pkg::*; (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // bench control: enable and answer delay
  input logic on,
  input logic [2:0] lag,
  // timer side
  input logic req,
  input logic [DATA_W-1:0] rdata,
  output logic rd,
  output logic ack
);
  logic [DATA_W-1:0] mem [0:15];
  logic [3:0] wp;
  logic [2:0] st;
  logic [2:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      cnt <= '0;
      wp <= '0;
      rd <= 1'b0;
      ack <= 1'b0;
    end else begin
      rd <= 1'b0;
      ack <= 1'b0;
      case (st)
        3'd0: if (on && req) begin
          cnt <= lag;
          st <= 3'd1;
        end
        3'd1: if (cnt == 3'd0) begin
          rd <= 1'b1;
          st <= 3'd2;
        end else begin
          cnt <= cnt - 3'd1;
        end
        3'd2: st <= 3'd3;
        3'd3: begin
          mem[wp] <= rdata;
          wp <= wp + 4'd1;
          ack <= 1'b1;
          st <= 3'd4;
        end
        default: st <= 3'd0;
      endcase
    end
  end
endmodule : ecc_dma_model

// ==== dv/ext_clocked_capture_counter_tb_top.sv ====
// self-checking testbench of the externally clocked capture counter
`timescale 1ns/10ps
module ext_clocked_capture_counter_tb_top import ecc_pkg::*; ;
  logic CLK = 0, RST_B = 0, wr_s = 0, rd_s = 0, pin = 0, ch2 = 0, dma_on = 0, ce = 1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, RDATA, v;
  logic [TRIG_N-1:0] itrig = '0;
  logic [2:0] lag = '0;
  logic TRIG_OUT, DMA_REQ, DMA_ACK, IRQ, dma_rd;
  int err_total = 0, n_checks = 0, cyc = 0, n, g[4];
  initial forever #12.5 CLK = ~CLK;
  ecc_timer ecc_timer_inst (.CLK(CLK), .CE(ce), .RST_B(RST_B), .ADDR(dma_rd ? A_CAPT2 : addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s | dma_rd), .RDATA(RDATA), .CH1_EXT_TRIG(pin), .CH2_IN(ch2), .INT_TRIG(itrig),
    .TRIG_OUT(TRIG_OUT), .DMA_REQ(DMA_REQ), .DMA_ACK(DMA_ACK), .IRQ(IRQ));
  ecc_dma_model ecc_dma_model_inst (.clk(CLK), .rst_n(RST_B), .on(dma_on), .lag(lag), .req(DMA_REQ),
    .rdata(RDATA), .rd(dma_rd), .ack(DMA_ACK));
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] o);
    n_checks++;
    if (o !== e) begin
      $display("[FAIL] %s expected %h seen %h", s, e, o);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge CLK);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge CLK);
    rd_s <= 1'b0;
    @(negedge CLK);
    v = RDATA;
    chk(s, e, v);
  endtask : rchk
  task automatic cfg(input logic [31:0] c);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_COUNT, 32'h0000_0000);
    wr(A_CTRL, c);
  endtask : cfg
  task automatic toggle(input int k);
    repeat (k) begin
      @(posedge CLK);
      pin <= ~pin;
      repeat (1 + $urandom % 4) @(posedge CLK);
    end
    repeat (12) @(posedge CLK);
  endtask : toggle
  task automatic trig(input int j);
    @(posedge CLK);
    itrig <= TRIG_N'(1) << j;
    @(posedge CLK);
    itrig <= '0;
    repeat (4) @(posedge CLK);
  endtask : trig
  task automatic cap(input int k);
    @(posedge CLK);
    ch2 <= 1'b1;
    repeat (2) @(posedge CLK);
    ch2 <= 1'b0;
    repeat (k - 2) @(posedge CLK);
  endtask : cap
  task automatic wgap();
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (TRIG_OUT !== 1'b1 && n < 64);
  endtask : wgap
  initial begin
    logic [31:0] lim;
    int p, e, k;
    void'($urandom(32'h69a6));
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    // reset values and an unmapped place
    rchk("ctrl", A_CTRL, 32'h0000_0000);
    rchk("limit", A_LIMIT, 32'hFFFF_FFFF);
    rchk("capt2", A_CAPT2, 32'h0000_0000);
    rchk("unmapped", 8'h18, 32'h0000_0000);
    // mode 2 with mode 1 both edges also set: one polarity, divided
    for (p = 0; p < 4; p++) begin
      cfg(1 << B_EN | 1 << B_EXT2 | ($urandom % 2) << B_FALL | p << B_PRESC | 32'(SLAVE_EXTCLK1) << B_SLAVE
        | 32'(EDGE_BOTH) << B_EDGE1);
      toggle(16);
      rchk("mode2 count", A_COUNT, 32'(8 >> p));
    end
    // reset slave beside mode 2, divide by four
    k = $urandom % TRIG_N;
    cfg(1 << B_EN | 1 << B_EXT2 | 32'(PRESC_DIV4) << B_PRESC | 32'(SLAVE_RESET) << B_SLAVE | k << B_TRIG_SRC);
    toggle(12);
    rchk("pre trig", A_COUNT, 32'h0000_0001);
    trig((k + 1) % TRIG_N);
    rchk("other trig", A_COUNT, 32'h0000_0001);
    trig(k);
    rchk("reset trig", A_COUNT, 32'h0000_0000);
    toggle(12);
    rchk("divider cleared", A_COUNT, 32'h0000_0001);
    // update period and trigger out
    lim = 3 + $urandom % 7;
    wr(A_LIMIT, lim);
    cfg(1 << B_EN | 32'(MASTER_UPDATE) << B_MASTER);
    wgap();
    wgap();
    chk("trig period", lim + 1, 32'(n));
    // interrupt: raise, mask, clear
    wr(A_CTRL, 32'h0000_0000);
    wr(A_STATUS, 32'h0000_000E);
    rchk("status upd", A_STATUS, 32'h0000_0001);
    chk("irq masked", 0, IRQ);
    wr(A_MASK, 32'h0000_0001);
    repeat (2) @(negedge CLK);
    chk("irq on", 1, IRQ);
    wr(A_STATUS, 32'h0000_0001);
    repeat (2) @(negedge CLK);
    chk("irq clear", 0, IRQ);
    cfg(1 << B_EN);
    wgap();
    chk("no trig", 64, 32'(n));
    // captures moved by the dma, channel 1 pin busy meanwhile
    wr(A_LIMIT, 32'hFFFF_FFFF);
    wr(A_STATUS, 32'h0000_000F);
    cfg(1 << B_EN | 1 << B_DMA_EN);
    wr(A_COUNT, 32'hFFFF_F000);
    lag <= 3'($urandom);
    dma_on <= 1'b1;
    for (e = 0; e < 4; e++) begin
      g[e] = 20 + $urandom % 30;
      pin <= 1'($urandom);
      cap(g[e]);
    end
    repeat (20) @(posedge CLK);
    dma_on <= 1'b0;
    pin <= 1'b0;
    chk("dma words", 4, 32'(ecc_dma_model_inst.wp));
    chk("capt high", 32'h000F_FFFF, 32'(ecc_dma_model_inst.mem[0][31:12]));
    for (e = 1; e < 4; e++) begin
      chk("capt gap", 32'(g[e - 1] + 1), ecc_dma_model_inst.mem[e] - ecc_dma_model_inst.mem[e - 1]);
    end
    // overcapture with dma request off
    wr(A_CTRL, 1 << B_EN);
    wr(A_STATUS, 32'h0000_000F);
    cap(4);
    rchk("cap flag", A_STATUS, 32'h0000_0002);
    cap(4);
    rchk("ovr flag", A_STATUS, 32'h0000_0006);
    chk("no dma req", 0, DMA_REQ);
    // mode 1 edge codes
    for (e = 0; e < 4; e++) begin
      cfg(1 << B_EN | 32'(SLAVE_EXTCLK1) << B_SLAVE | e << B_EDGE1);
      toggle(6);
      rchk("mode1 count", A_COUNT, (e == 2) ? 32'h0000_0006 : 32'h0000_0003);
    end
    // clock enable low freezes counting and drops strobes
    cfg(1 << B_EN | 32'(SLAVE_EXTCLK1) << B_SLAVE);
    ce <= 1'b0;
    wr(A_COUNT, 32'h0000_0005);
    toggle(6);
    ce <= 1'b1;
    rchk("ce freeze", A_COUNT, 32'h0000_0000);
    results();
  end
endmodule : ext_clocked_capture_counter_tb_top
